//--- core/fes_host.sv
// Host-side controller that runs bus cycles and toggle polling on a parallel flash.
// Assumes software on APB, flash pins wired straight to the device, one clock.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Host recovers from timeout failure by issuing the reset command.
// - Host reads timer bit before and after each added sector erase.
// - Host reads status at least twice and compares toggle bits.
// - Toggling with fail bit high: recheck; still toggling means reset.
// - Host restarts toggle check from first step after interruption.
module fes_host
   import fes_pkg::*;
#(
   parameter int WP_CYCLES = WP_CYC
) (
   input  wire logic        MCLK,
   input  wire logic        RESET,
   input  wire logic        CKEN,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   output logic      [19:0] FA,
   output logic      [7:0]  FDQ_O,
   input  wire logic [7:0]  FDQ_I,
   output logic             FDQ_OE,
   output logic             FCE_N,
   output logic             FOE_N,
   output logic             FWE_N
);
   // ==========================================================
   // State
   fes_state_t  st_r, st_nxt;
   logic [2:0]  op_r, op_nxt;
   logic [1:0]  step_r, step_nxt;
   logic [7:0]  cnt_r, cnt_nxt;
   logic [7:0]  rd_r, rd_nxt, prev_r, prev_nxt;
   logic [3:0]  rdc_r, rdc_nxt;
   logic [19:0] addr_r, addr_nxt;
   logic [7:0]  wdata_r, wdata_nxt;
   logic        done_r, done_nxt, fail_r, fail_nxt, rej_r, rej_nxt, tog2_r, tog2_nxt;
   logic [19:0] fa_r, fa_nxt;
   logic [7:0]  fdo_r, fdo_nxt;
   logic        foe_r, foe_nxt, fce_n_r, fce_n_nxt, foe_n_r, foe_n_nxt, fwe_n_r, fwe_n_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic [7:0]  dq_s1_r, dq_s2_r;
   logic        apb_wr, mapped;

   // Only the second flop is read; pins are asynchronous to MCLK
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         dq_s1_r <= 8'h00;
         dq_s2_r <= 8'h00;
      end else if (CKEN) begin
         dq_s1_r <= FDQ_I;
         dq_s2_r <= dq_s1_r;
      end
   end

   // ==========================================================
   // APB slave, zero wait states
   assign apb_wr  = PSEL & PENABLE & PWRITE;
   assign mapped  = (PADDR == REG_CMD) | (PADDR == REG_ADDR) | (PADDR == REG_WDATA) |
                    (PADDR == REG_RDATA) | (PADDR == REG_STATUS);
   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL & PENABLE & ~mapped;
   assign PRDATA  = prdata_r;
   assign FA      = fa_r;
   assign FDQ_O   = fdo_r;
   assign FDQ_OE  = foe_r;
   assign FCE_N   = fce_n_r;
   assign FOE_N   = foe_n_r;
   assign FWE_N   = fwe_n_r;

   // Next values for all controller state
   always_comb begin
      st_nxt = st_r;  op_nxt = op_r;  step_nxt = step_r;  cnt_nxt = cnt_r;
      rd_nxt = rd_r;  prev_nxt = prev_r;  rdc_nxt = rdc_r;
      addr_nxt = addr_r;  wdata_nxt = wdata_r;
      done_nxt = done_r;  fail_nxt = fail_r;  rej_nxt = rej_r;  tog2_nxt = tog2_r;
      fa_nxt = fa_r;  fdo_nxt = fdo_r;  foe_nxt = foe_r;
      fce_n_nxt = fce_n_r;  foe_n_nxt = foe_n_r;  fwe_n_nxt = fwe_n_r;
      prdata_nxt = prdata_r;
      // Read data latched in setup phase so it leaves a flop
      if (PSEL && !PENABLE && !PWRITE) begin
         case (PADDR)
            REG_ADDR:   prdata_nxt = {12'h000, addr_r};
            REG_WDATA:  prdata_nxt = {24'h000000, wdata_r};
            REG_RDATA:  prdata_nxt = {24'h000000, rd_r};
            REG_STATUS: prdata_nxt = {27'h0000000, tog2_r, rej_r, fail_r, done_r, st_r != S_IDLE};
            default:    prdata_nxt = 32'h00000000;
         endcase
      end
      case (st_r)
         S_IDLE: begin
            // Setup writes while busy are ignored so a cycle never sees them change
            if (apb_wr && PADDR == REG_ADDR) addr_nxt = PWDATA[19:0];
            if (apb_wr && PADDR == REG_WDATA) wdata_nxt = PWDATA[7:0];
            if (apb_wr && PADDR == REG_CMD && PWDATA[2:0] >= OP_READ && PWDATA[2:0] <= OP_ADDSEC) begin
               op_nxt = PWDATA[2:0];
               step_nxt = 2'd0;
               rdc_nxt  = 4'd0;
               done_nxt = 1'b0;  fail_nxt = 1'b0;  rej_nxt = 1'b0;  tog2_nxt = 1'b0;
               fa_nxt = addr_r;  cnt_nxt = 8'h00;  fce_n_nxt = 1'b0;
               if (PWDATA[2:0] == OP_WRITE || PWDATA[2:0] == OP_RESET) begin
                  fdo_nxt = (PWDATA[2:0] == OP_RESET) ? CMD_RESET : wdata_r;
                  foe_nxt = 1'b1;  fwe_n_nxt = 1'b0;  st_nxt = S_WR_LO;
               end else begin
                  foe_n_nxt = 1'b0;  st_nxt = S_RD;
               end
            end
         end
         S_RD: begin
            // Strobe stays low through access time plus synchroniser
            cnt_nxt = cnt_r + 8'h01;
            if (cnt_r == 8'(RD_CYC)) begin
               rd_nxt = dq_s2_r;
               rdc_nxt = rdc_r + 4'd1;
               fce_n_nxt = 1'b1;  foe_n_nxt = 1'b1;  st_nxt = S_DECIDE;
            end
         end
         S_WR_LO: begin
            cnt_nxt = cnt_r + 8'h01;
            if (cnt_r == 8'(WP_CYCLES - 1)) begin
               fwe_n_nxt = 1'b1;  st_nxt = S_WR_HI;  // Data held past the rising edge
            end
         end
         S_WR_HI: begin
            fce_n_nxt = 1'b1;  foe_nxt = 1'b0;  st_nxt = S_DECIDE;
         end
         S_DECIDE: begin
            // One idle cycle between cycles lets output-enable toggle every read
            st_nxt = S_IDLE;  done_nxt = 1'b1;  cnt_nxt = 8'h00;
            if (op_r == OP_POLL) begin
               prev_nxt = rd_r;
               case (step_r)
                  2'd0: begin
                     step_nxt = 2'd1;  done_nxt = 1'b0;
                  end
                  2'd1: begin
                     tog2_nxt = rd_r[BIT_TOG2] ^ prev_r[BIT_TOG2];
                     if (rd_r[BIT_TOG] != prev_r[BIT_TOG]) begin
                        done_nxt = 1'b0;
                        // fail bit high, recheck once more
                        if (rd_r[BIT_FAIL]) begin
                           step_nxt = 2'd2;
                        end else begin
                           step_nxt = 2'd0;
                           rdc_nxt = 4'd0;
                        end
                     end
                  end
                  default: begin
                     if (rd_r[BIT_TOG] != prev_r[BIT_TOG]) begin
                        // still toggling, recover with reset command
                        fail_nxt = 1'b1;  done_nxt = 1'b0;  op_nxt = OP_RESET;
                        fdo_nxt = CMD_RESET;  foe_nxt = 1'b1;  fwe_n_nxt = 1'b0;
                        fce_n_nxt = 1'b0;  st_nxt = S_WR_LO;
                     end
                  end
               endcase
               if (done_nxt == 1'b0 && st_nxt == S_IDLE) begin
                  fce_n_nxt = 1'b0;  foe_n_nxt = 1'b0;  st_nxt = S_RD;
               end
            end else if (op_r == OP_ADDSEC) begin
               // timer bit read before and after the added erase
               case (step_r)
                  2'd0: begin
                     if (rd_r[BIT_TMR]) begin
                        rej_nxt = 1'b1;
                     end else begin
                        step_nxt = 2'd1;  done_nxt = 1'b0;
                        fdo_nxt = CMD_SEC_ERASE;  foe_nxt = 1'b1;
                        fce_n_nxt = 1'b0;  fwe_n_nxt = 1'b0;  st_nxt = S_WR_LO;
                     end
                  end
                  2'd1: begin
                     step_nxt = 2'd2;  done_nxt = 1'b0;
                     fce_n_nxt = 1'b0;  foe_n_nxt = 1'b0;  st_nxt = S_RD;
                  end
                  default: rej_nxt = rd_r[BIT_TMR];
               endcase
            end
         end
         default: st_nxt = S_IDLE;
      endcase
   end

   // Register everything; clock enable freezes all state
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         st_r <= S_IDLE;  op_r <= 3'h0;  step_r <= 2'd0;  cnt_r <= 8'h00;
         rd_r <= 8'h00;  prev_r <= 8'h00;  rdc_r <= 4'd0;
         addr_r <= 20'h00000;  wdata_r <= 8'h00;
         done_r <= 1'b0;  fail_r <= 1'b0;  rej_r <= 1'b0;  tog2_r <= 1'b0;
         fa_r <= 20'h00000;  fdo_r <= 8'h00;  foe_r <= 1'b0;
         fce_n_r <= 1'b1;  foe_n_r <= 1'b1;  fwe_n_r <= 1'b1;
         prdata_r <= 32'h00000000;
      end else if (CKEN) begin
         st_r <= st_nxt;  op_r <= op_nxt;  step_r <= step_nxt;  cnt_r <= cnt_nxt;
         rd_r <= rd_nxt;  prev_r <= prev_nxt;  rdc_r <= rdc_nxt;
         addr_r <= addr_nxt;  wdata_r <= wdata_nxt;
         done_r <= done_nxt;  fail_r <= fail_nxt;  rej_r <= rej_nxt;  tog2_r <= tog2_nxt;
         fa_r <= fa_nxt;  fdo_r <= fdo_nxt;  foe_r <= foe_nxt;
         fce_n_r <= fce_n_nxt;  foe_n_r <= foe_n_nxt;  fwe_n_r <= fwe_n_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   // ==========================================================
   // Checks
   chk_fail_resets: assert property (@(posedge MCLK) disable iff (RESET)
      $rose(fail_r) |-> (!FWE_N && FDQ_OE && FDQ_O == CMD_RESET))
      else $error("fail flagged without reset command on the bus");
   chk_poll_two_reads: assert property (@(posedge MCLK) disable iff (RESET)
      (CKEN && st_r == S_DECIDE && op_r == OP_POLL && done_nxt) |-> rdc_r >= 4'd2)
      else $error("poll finished on fewer than two reads");
   chk_fail_recheck: assert property (@(posedge MCLK) disable iff (RESET)
      (CKEN && st_r == S_DECIDE && op_r == OP_POLL && step_r == 2'd1 &&
       rd_r[BIT_TOG] != prev_r[BIT_TOG] && rd_r[BIT_FAIL]) |=> (step_r == 2'd2 && st_r == S_RD && !FOE_N))
      else $error("fail bit high without a third read");
   chk_poll_restart: assert property (@(posedge MCLK) disable iff (RESET)
      (CKEN && st_r == S_IDLE && apb_wr && PADDR == REG_CMD && PWDATA[2:0] == OP_POLL)
      |=> (step_r == 2'd0 && rdc_r == 4'd0 && st_r == S_RD))
      else $error("poll did not start from first read");
   chk_addsec_order: assert property (@(posedge MCLK) disable iff (RESET)
      (st_r == S_WR_HI && op_r == OP_ADDSEC && CKEN) |-> ##[2:4] (st_r == S_RD && step_r == 2'd2))
      else $error("timer bit not read after added erase");
endmodule // fes_host
`default_nettype wire

//--- core/fes_pkg.sv
// Shared constants for the flash status-polling host controller.
// Assumes a 50 MHz controller clock and one asynchronous parallel flash bus.
package fes_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_NS    = 20;
   localparam int T_ACC_NS  = 100;                              // Read access time
   localparam int ACC_CYC   = (T_ACC_NS + CLK_NS - 1) / CLK_NS;  // Least time, rounded up
   localparam int SYNC_CYC  = 2;                                // Input synchroniser depth
   localparam int RD_CYC    = ACC_CYC + SYNC_CYC;               // Strobe low until sample
   localparam int T_WP_NS   = 60;                               // Write pulse width, plain default
   localparam int WP_CYC    = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   // ==========================================================
   // APB register offsets
   localparam logic [7:0] REG_CMD    = 8'h00;
   localparam logic [7:0] REG_ADDR   = 8'h04;
   localparam logic [7:0] REG_WDATA  = 8'h08;
   localparam logic [7:0] REG_RDATA  = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   // Status register fields
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_FAIL = 2;
   localparam int ST_REJ  = 3;
   localparam int ST_TOG2 = 4;
   // ==========================================================
   // Operations written to the command register
   localparam logic [2:0] OP_READ   = 3'h1;
   localparam logic [2:0] OP_WRITE  = 3'h2;
   localparam logic [2:0] OP_POLL   = 3'h3;
   localparam logic [2:0] OP_RESET  = 3'h4;
   localparam logic [2:0] OP_ADDSEC = 3'h5;
   // Flash status bit positions and command bytes
   localparam int BIT_TOG  = 6;   // primary_toggle_bit
   localparam int BIT_FAIL = 5;   // timeout_fail_bit
   localparam int BIT_TMR  = 3;   // erase_timer_bit
   localparam int BIT_TOG2 = 2;   // secondary_toggle_bit
   localparam logic [7:0] CMD_RESET     = 8'hF0;
   localparam logic [7:0] CMD_SEC_ERASE = 8'h30;
   // ==========================================================
   // Controller states
   typedef enum logic [2:0] {S_IDLE, S_RD, S_WR_LO, S_WR_HI, S_DECIDE} fes_state_t;
endpackage

//--- sim/fes_flash_model.sv
// Behavioural parallel flash answering the host controller's strobes.
// Assumes the bench starts and configures embedded operations via its ports.
`timescale 1ns/10ps
`default_nettype none
module fes_flash_model
   import fes_pkg::*;
(
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic [19:0] addr,
   input  wire logic [7:0]  din,
   output logic      [7:0]  dout,
   input  wire logic        start,
   input  wire logic [31:0] busy_len,
   input  wire logic        fail_en,
   input  wire logic        timer_closed,
   input  wire logic [1:0]  mode,
   output logic             reset_seen
);
   // Kind of embedded operation the bench starts
   localparam logic [1:0] M_ERASE   = 2'h0;
   localparam logic [1:0] M_PROG    = 2'h1;
   localparam logic [1:0] M_SUSP_RD = 2'h2;
   localparam logic [1:0] M_SUSP_PG = 2'h3;
   // ==========================================================
   // State
   logic [7:0] mem [0:255];
   logic [7:0] last, rdv, last_wr;
   logic       tog, tog2, fail, busy, rd_on, erasing, st7, st6, st2;
   int         cnt;
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
      {cnt, tog, tog2, fail, last, last_wr, reset_seen} = '0;
   end
   assign busy    = (cnt > 0) || fail;
   assign erasing = (mode == M_ERASE);
   // One read spans both strobes low; both rise on one edge, so no race
   assign rd_on   = !ce_n && !oe_n;
   // polling bit: complement of last data when programming, 0 when erasing
   assign st7 = erasing ? 1'b0 : (mode == M_SUSP_RD) ? 1'b1 : ~last_wr[7];
   assign st6 = (mode == M_SUSP_RD) ? 1'b1 : tog;
   // secondary bit steady 1 while programming
   assign st2 = (mode == M_PROG || mode == M_SUSP_PG) ? 1'b1 : tog2;
   assign rdv = busy ? {st7, st6, fail, 1'b0, erasing & timer_closed, st2, 2'b00} : mem[addr[7:0]];
   // Released bus shows the inverse so stale data never passes
   assign dout = rd_on ? rdv : ~last;
   // start stands for the rising edge of the last write pulse
   always @(posedge start) begin
      cnt = int'(busy_len);
      fail = fail_en;
      reset_seen = 1'b0;
      tog = 1'b0;
      tog2 = 1'b0;
   end
   always @(negedge rd_on) begin
      last = rdv;
      if (busy) begin
         if (mode != M_SUSP_RD) tog = ~tog;
         tog2 = ~tog2;
         if (!fail) cnt = cnt - 1;
      end
   end
   always @(posedge we_n) if (!ce_n) begin
      if (din == CMD_RESET) begin
         cnt = 0;
         fail = 1'b0;
         reset_seen = 1'b1;
      end else begin
         last_wr = din;
         // busy device leaves memory unchanged
         if (!busy) mem[addr[7:0]] = din;
      end
   end
endmodule // fes_flash_model
`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the flash status-polling host controller.
// Assumes the behavioural flash model stands on the far side of the pins.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb;
   import fes_pkg::*;
   // ==========================================================
   // Signals
   logic        MCLK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, start = 0, fail_en = 0, tmr = 0;
   logic        CKEN = 1;
   logic [1:0]  mode = 0;
   logic [7:0]  PADDR = 0, FDQ_O, mdq, fdq_i;
   logic [31:0] PWDATA = 0, PRDATA, st, rd;
   logic        PREADY, PSLVERR, FDQ_OE, FCE_N, FOE_N, FWE_N, rst_seen, err;
   logic [19:0] FA;
   int          blen = 0, num_errors = 0, total_checks = 0;
   always #10 MCLK = ~MCLK;
   // Host drives the data pins during writes
   assign fdq_i = FDQ_OE ? FDQ_O : mdq;
   fes_host dut_u (.MCLK(MCLK), .RESET(RESET), .CKEN(CKEN), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .FA(FA), .FDQ_O(FDQ_O), .FDQ_I(fdq_i), .FDQ_OE(FDQ_OE),
      .FCE_N(FCE_N), .FOE_N(FOE_N), .FWE_N(FWE_N));
   fes_flash_model flash_u (.ce_n(FCE_N), .oe_n(FOE_N), .we_n(FWE_N), .addr(FA), .din(fdq_i),
      .dout(mdq), .start(start), .busy_len(blen), .fail_en(fail_en), .timer_closed(tmr),
      .mode(mode), .reset_seen(rst_seen));
   // ==========================================================
   // APB master tasks
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge MCLK);
      PSEL <= 1; PENABLE <= 0; PWRITE <= w; PADDR <= a; PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1;
      @(posedge MCLK);
      while (PREADY !== 1'b1) @(posedge MCLK);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 0; PENABLE <= 0;
   endtask
   task automatic wait_idle;
      int n;
      n = 0;
      st = 32'h1;
      while (st[ST_BUSY] !== 1'b0 && n < 5000) begin
         apb(0, REG_STATUS, 0);
         st = rd;
         n++;
      end
      // A hung controller ends the run as a failure
      if (n >= 5000) begin
         num_errors++;
         test_done;
      end
   endtask
   task automatic run_op(input logic [19:0] a, input logic [2:0] op);
      apb(1, REG_ADDR, {12'h000, a});
      apb(1, REG_CMD, {29'h0, op});
      wait_idle;
   endtask
   task automatic kick(input int len, input logic f, input logic t, input logic [1:0] m);
      blen <= len; fail_en <= f; tmr <= t; mode <= m;
      @(posedge MCLK);
      start <= 1;
      @(posedge MCLK);
      start <= 0;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_regs;
      apb(0, REG_STATUS, 0);
      `CHK(rd, 32'h0)
      apb(0, 8'h20, 0);
      `CHK({err, rd}, {1'b1, 32'h0})
   endtask
   task automatic t_rw;
      run_op(20'h12, OP_READ);
      apb(0, REG_RDATA, 0);
      `CHK(rd[7:0], 8'h12 ^ 8'h5A)
      apb(1, REG_WDATA, 32'h3C);
      run_op(20'h12, OP_WRITE);
      run_op(20'h12, OP_READ);
      apb(0, REG_RDATA, 0);
      `CHK(rd[7:0], 8'h3C)
   endtask
   // Suspend-program after data 3C was written: polling bit 1, secondary bit 1
   task automatic t_prog;
      kick(20, 0, 0, 2'h3);
      run_op(20'h12, OP_READ);
      apb(0, REG_RDATA, 0);
      `CHK(rd[7:0], 8'h84)
      // Freeze mid-read: no extra strobe edge may reach the flash
      apb(1, REG_CMD, {29'h0, OP_READ});
      CKEN <= 0;
      repeat (20) @(posedge MCLK);
      `CHK({FCE_N, FOE_N}, 2'b00)
      CKEN <= 1;
      wait_idle;
      apb(0, REG_RDATA, 0);
      `CHK(rd[7:0], 8'hC4)
      `CHK(rd[BIT_TOG2], 1'b1)
   endtask
   task automatic t_poll_ok;
      kick(6, 0, 0, 2'h0);
      run_op(20'h0, OP_POLL);
      `CHK({st[ST_TOG2], st[2:0]}, 4'b0010)
      apb(0, REG_RDATA, 0);
      `CHK(rd[7:0], 8'h5A)
   endtask
   // Suspend-read: primary steady, secondary alternates, poll ends on two reads
   task automatic t_susp;
      kick(6, 0, 0, 2'h2);
      run_op(20'h0, OP_POLL);
      `CHK({st[ST_TOG2], st[2:0]}, 4'b1010)
      apb(0, REG_RDATA, 0);
      `CHK(rd[7:0], 8'hC4)
   endtask
   task automatic t_poll_fail;
      kick(1, 1, 0, 2'h0);
      run_op(20'h0, OP_POLL);
      // Reset write ends through the decide state, which marks done
      `CHK({st[ST_TOG2], st[2:0]}, 4'b1110)
      `CHK(rst_seen, 1'b1)
      run_op(20'h0, OP_READ);
      apb(0, REG_RDATA, 0);
      `CHK(rd[7:0], 8'h5A)
   endtask
   task automatic t_addsec;
      for (int k = 0; k < 2; k++) begin
         kick(50, 0, k[0], 2'h0);
         run_op(20'h4, OP_ADDSEC);
         `CHK(st[ST_REJ], k[0])
         run_op(20'h0, OP_RESET);
         `CHK(rst_seen, 1'b1)
      end
   endtask
   // ==========================================================
   // Verdict and sequence
   task automatic test_done;
      if (num_errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge MCLK);
      RESET <= 0;
      t_regs;
      t_rw;
      t_prog;
      t_poll_ok;
      t_susp;
      t_poll_fail;
      t_addsec;
      test_done;
   end
   // Watchdog at 50k cycles, far beyond the few hundred the tests need
   initial begin
      #1000000;
      num_errors++;
      test_done;
   end
endmodule // tb
`default_nettype wire
